/* bench/serial_port_asserts.sv */
// Checker for the serial port, watching only the top-level ports.
// Assumes one clock domain and a baud tick on that clock.
`timescale 1ns/1ps
`default_nettype none
module serial_port_checker (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register bus
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic [7:0] sfr_rdata_o,
   // Line and status
   input wire logic baud_tick_i,
   input wire logic rx_i,
   input wire logic tx_o,
   input wire logic irq_o,
   input wire logic tx_buf_ready_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // ***************
   // Helper logic
   // ***************
   // Baud ticks seen while the transmit line is low
   logic [7:0] low_ticks_reg;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         low_ticks_reg <= 8'h00;
      end else if (tx_o) begin
         low_ticks_reg <= 8'h00;
      end else if (baud_tick_i) begin
         low_ticks_reg <= low_ticks_reg + 8'h01;
      end
   end

   sequence ctrl_wr;
      sfr_wr_i && sfr_addr_i == serial_pkg::CTRL_ADDR;
   endsequence
   sequence ctrl_rd;
      sfr_rd_i && sfr_addr_i == serial_pkg::CTRL_ADDR;
   endsequence

   // ***************
   // Assertions
   // ***************
   a_ctrl_bit_six: assert property (
      ctrl_rd |=> sfr_rdata_o[serial_pkg::UNUSED_BIT])
      else $error("control bit 6 read as zero");
   a_ctrl_readback: assert property (
      ctrl_wr ##1 !sfr_wr_i ##1 ctrl_rd |=>
      (sfr_rdata_o & 8'hb8) == ($past(sfr_wdata_i, 3) & 8'hb8))
      else $error("control fields not kept");
   a_irq_mirror: assert property (
      ctrl_rd |=> (|sfr_rdata_o[1:0]) == $past(irq_o))
      else $error("irq differs from done flags");
   a_irq_sw_set: assert property (
      ctrl_wr and (|sfr_wdata_i[1:0]) |=> irq_o)
      else $error("written done flag did not set");
   a_unmapped_zero: assert property (
      sfr_rd_i && sfr_addr_i != serial_pkg::CTRL_ADDR
      && sfr_addr_i != serial_pkg::DATA_ADDR |=> sfr_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (
      !sfr_rd_i |=> $stable(sfr_rdata_o))
      else $error("read data changed without read");
   a_reset_idle: assert property (
      $fell(rst_i) |-> tx_o && !irq_o && tx_buf_ready_o)
      else $error("outputs not idle after reset");
   a_ready_fall: assert property (
      $fell(tx_buf_ready_o) |-> $past(sfr_wr_i) && $past(sfr_addr_i) == serial_pkg::DATA_ADDR)
      else $error("buffer filled without data write");
   a_tx_low_span: assert property (
      $rose(tx_o) |-> low_ticks_reg >= 8'h0f && (low_ticks_reg + 8'h01) % 8'h10 <= 8'h02)
      else $error("low stretch not whole bit times");
endmodule

bind serial_port serial_port_checker u_checker (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .sfr_addr_i(sfr_addr_i),
   .sfr_wr_i(sfr_wr_i),
   .sfr_rd_i(sfr_rd_i),
   .sfr_wdata_i(sfr_wdata_i),
   .sfr_rdata_o(sfr_rdata_o),
   .baud_tick_i(baud_tick_i),
   .rx_i(rx_i),
   .tx_o(tx_o),
   .irq_o(irq_o),
   .tx_buf_ready_o(tx_buf_ready_o)
);
`default_nettype wire

/* bench/serial_remote.sv */
// Remote serial transceiver on the far end of the line.
// Assumes the same baud tick as the port, sixteen ticks a bit.
`timescale 1ns/1ps
`default_nettype none
module serial_remote (
   // Clock and tick
   input wire logic clk_i,
   input wire logic tick_i,
   // Serial line
   input wire logic line_i,
   output logic line_o
);
   int nbits = 8;
   int n_got = 0;
   logic [9:0] got;
   logic [9:0] q[$];
   logic stop_phase = 1'b0;

   initial line_o = 1'b1;

   task automatic hold_bit(input logic b);
      @(negedge clk_i);
      line_o = b;
      repeat (16) @(posedge clk_i iff tick_i);
   endtask

   task automatic send(input logic [8:0] d, input logic stop);
      hold_bit(1'b0);
      for (int i = 0; i < nbits; i++) hold_bit(d[i]);
      stop_phase = 1'b1;
      hold_bit(stop);
      stop_phase = 1'b0;
      @(negedge clk_i);
      line_o = 1'b1;
   endtask

   always begin
      @(negedge line_i);
      n_got = 0;
      repeat (8) @(posedge clk_i iff tick_i);
      for (int i = 0; i <= nbits; i++) begin
         repeat (16) @(posedge clk_i iff tick_i);
         got[i] = line_i;
         n_got = i + 1;
      end
      q.push_back(got);
   end
endmodule
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the serial port.
// Assumes the remote model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct packed {
      logic fmt;
      logic mce;
      logic ren;
      logic pre;
      logic [7:0] d;
      logic n9;
      logic stop;
      logic ok;
   } rx_case_s;
   localparam logic [7:0] CTRL = serial_pkg::CTRL_ADDR;
   localparam logic [7:0] DATA = serial_pkg::DATA_ADDR;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] sfr_addr_i = 8'h00;
   logic sfr_wr_i = 1'b0;
   logic sfr_rd_i = 1'b0;
   logic [7:0] sfr_wdata_i = 8'h00;
   logic [7:0] sfr_rdata_o;
   logic baud_tick_i = 1'b0;
   logic rx_i;
   logic tx_o;
   logic irq_o;
   logic tx_buf_ready_o;
   int n_errors = 0;
   int cmp_count = 0;
   logic [7:0] rd_val;
   logic [7:0] exp_data = 8'h00;
   logic exp_rb8 = 1'b0;
   rx_case_s cases [8] = '{
      {3'b001, 1'b0, 8'h5a, 3'b001}, {3'b011, 1'b0, 8'ha5, 3'b000},
      {3'b011, 1'b0, 8'hc3, 3'b011}, {3'b101, 1'b0, 8'h0f, 3'b001},
      {3'b111, 1'b0, 8'hf0, 3'b010}, {3'b111, 1'b0, 8'h81, 3'b111},
      {3'b101, 1'b1, 8'h7e, 3'b010}, {3'b000, 1'b0, 8'he7, 3'b010}};

   always #50 clk_i = ~clk_i;
   always @(negedge clk_i) baud_tick_i <= ~baud_tick_i;

   serial_port uut (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sfr_addr_i(sfr_addr_i),
      .sfr_wr_i(sfr_wr_i),
      .sfr_rd_i(sfr_rd_i),
      .sfr_wdata_i(sfr_wdata_i),
      .sfr_rdata_o(sfr_rdata_o),
      .baud_tick_i(baud_tick_i),
      .rx_i(rx_i),
      .tx_o(tx_o),
      .irq_o(irq_o),
      .tx_buf_ready_o(tx_buf_ready_o)
   );
   serial_remote remote (
      .clk_i(clk_i),
      .tick_i(baud_tick_i),
      .line_i(tx_o),
      .line_o(rx_i)
   );

   // ***************
   // Shared tasks
   // ***************
   task automatic check(input string what, input logic [8:0] e, input logic [8:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask

   // Bus tasks are entered at a falling edge and end after one idle cycle
   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      sfr_addr_i = a;
      sfr_wdata_i = d;
      sfr_wr_i = 1'b1;
      @(negedge clk_i);
      sfr_wr_i = 1'b0;
      @(negedge clk_i);
   endtask

   task automatic sfr_read(input logic [7:0] a);
      sfr_addr_i = a;
      sfr_rd_i = 1'b1;
      @(negedge clk_i);
      sfr_rd_i = 1'b0;
      rd_val = sfr_rdata_o;
      @(negedge clk_i);
   endtask

   task automatic close_out;
      $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ***************
   // Scenarios
   // ***************
   task automatic t_regs;
      sfr_read(CTRL);
      check("ctrl reset", 8'h40, rd_val);
      sfr_write(CTRL, 8'hbf);
      sfr_read(CTRL);
      check("ctrl all set", 8'hff, rd_val);
      check("irq set", 1'b1, irq_o);
      sfr_write(CTRL, 8'h00);
      sfr_read(CTRL);
      check("ctrl cleared", 8'h40, rd_val);
      check("irq clear", 1'b0, irq_o);
      sfr_read(8'h9a);
      check("unmapped", 8'h00, rd_val);
   endtask

   task automatic t_tx(input logic fmt, input logic tb8, input logic [7:0] d);
      int nb;
      logic [9:0] f;
      nb = fmt ? 9 : 8;
      remote.nbits = nb;
      sfr_write(CTRL, {fmt, 3'b000, tb8, exp_rb8, 2'b00});
      sfr_write(DATA, d);
      for (int i = 0; i < 600 && irq_o !== 1'b1; i++) @(negedge clk_i);
      check("bits at flag", 9'(nb), 9'(remote.n_got));
      for (int i = 0; i < 300 && remote.q.size() == 0; i++) @(negedge clk_i);
      f = remote.q.size() > 0 ? remote.q.pop_front() : 10'h000;
      check("tx byte", d, f[7:0]);
      check("tx stop", 1'b1, f[nb]);
      if (fmt) check("tx ninth", tb8, f[8]);
      sfr_read(CTRL);
      check("tx flag", 1'b1, rd_val[serial_pkg::TI_BIT]);
      sfr_write(CTRL, {fmt, 3'b000, tb8, exp_rb8, 2'b00});
   endtask

   task automatic t_burst;
      logic [9:0] f;
      remote.nbits = 8;
      sfr_write(CTRL, 8'h00);
      // Let the previous frame finish so that the shifter is free
      repeat (48) @(negedge clk_i);
      for (int i = 1; i <= 4; i++) sfr_write(DATA, 8'(8'h11 * i));
      check("buffer ready", 1'b0, tx_buf_ready_o);
      repeat (1400) @(negedge clk_i);
      check("frame count", 9'h003, 9'(remote.q.size()));
      for (int i = 1; i <= 3; i++) begin
         f = remote.q.size() > 0 ? remote.q.pop_front() : 10'h000;
         check("burst byte", 8'(8'h11 * i), f[7:0]);
      end
      sfr_write(CTRL, 8'h00);
   endtask

   task automatic t_rx(input rx_case_s c);
      remote.nbits = c.fmt ? 9 : 8;
      sfr_write(CTRL, {c.fmt, 1'b0, c.mce, c.ren, 1'b0, exp_rb8, 1'b0, c.pre});
      fork
         remote.send({c.n9, c.d}, c.stop);
         begin
            wait (remote.stop_phase);
            @(negedge clk_i);
            check("flag before stop", c.pre, irq_o);
         end
      join
      if (c.ok) begin
         exp_data = c.d;
         exp_rb8 = c.fmt ? c.n9 : c.stop;
      end
      check("rx flag", c.ok | c.pre, irq_o);
      sfr_read(DATA);
      check("rx data", exp_data, rd_val);
      sfr_read(CTRL);
      check("rx ninth", exp_rb8, rd_val[serial_pkg::RB8_BIT]);
      sfr_write(CTRL, {5'h00, exp_rb8, 2'b00});
   endtask

   initial begin
      repeat (4) @(negedge clk_i);
      rst_i = 1'b0;
      t_regs();
      t_tx(1'b0, 1'b0, 8'ha5);
      t_tx(1'b1, 1'b1, 8'h3c);
      t_tx(1'b1, 1'b0, 8'hc3);
      t_burst();
      foreach (cases[i]) t_rx(cases[i]);
      close_out();
   end

   initial begin
      #3000000;
      n_errors++;
      close_out();
   end
endmodule
`default_nettype wire

/* logic/serial_pkg.sv */
// Constants shared by the serial port, its checker and its testbench.
// Assumes a special-function-register bus with byte addresses.
package serial_pkg;
   // ************************************************
   // Register addresses and control reset value
   // ************************************************
   localparam logic [7:0] CTRL_ADDR = 8'h98;
   localparam logic [7:0] DATA_ADDR = 8'h99;
   localparam logic [7:0] CTRL_RESET = 8'h40;

   // ************************************************
   // Control field positions
   // ************************************************
   localparam int FMT_BIT = 7;
   localparam int UNUSED_BIT = 6;
   localparam int MCE_BIT = 5;
   localparam int REN_BIT = 4;
   localparam int TB8_BIT = 3;
   localparam int RB8_BIT = 2;
   localparam int TI_BIT = 1;
   localparam int RI_BIT = 0;

   // ************************************************
   // Bit timing in baud ticks, last data bit index and transmit buffer depth
   // ************************************************
   localparam int TICKS_PER_BIT = 16;
   localparam logic [3:0] BIT_LAST = 4'(TICKS_PER_BIT - 1);
   localparam logic [3:0] HALF_LAST = 4'(TICKS_PER_BIT / 2 - 1);
   localparam logic [2:0] DATA_LAST = 3'h7;
   localparam int TX_BUF_DEPTH = 2;

   typedef enum logic [2:0] {
      LINE_IDLE,
      LINE_START,
      LINE_DATA,
      LINE_NINTH,
      LINE_STOP
   } line_state_e;
endpackage

/* logic/serial_port.sv */
// Asynchronous serial port with 8-bit and 9-bit framing.
// Assumes a byte-wide register bus on clk_i and a 16x baud tick.
//
// Behaviour
// - 9-bit frame: start, eight LSB-first, ninth, stop
// - Ninth transmitted bit comes from tx_ninth_bit
// - 9-bit receive stores ninth bit, ignores stop
// - Writing serial_buffer starts a transmission; writes while tx_buf_ready_o is low are dropped
// - tx_done_flag set at stop start
// - Reception only while receive_enable_bit is one
// - 9-bit accept needs flag clear, address bit if multiproc_check_enable
// - Accepted frame loads data, ninth bit, flag
// - Interrupt request when either done flag set
// - frame_format_select chooses 8-bit or 9-bit
// - Control bit 6 reads one, ignores writes
// - 8-bit mode stop check by multiproc_check_enable
// - 8-bit mode stop level into rx_ninth_bit
// - rx_done_flag set at stop sample
`timescale 1ns/1ps
`default_nettype none
module serial_port (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register bus
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o,
   // Baud timing
   input wire logic baud_tick_i,
   // Serial line
   input wire logic rx_i,
   output logic tx_o,
   // Status
   output logic irq_o,
   output logic tx_buf_ready_o
);
   // ************************************************
   // Declarations
   // ************************************************
   logic fmt_reg;
   logic mce_reg;
   logic ren_reg;
   logic tb8_reg;
   logic rb8_reg;
   logic ti_reg;
   logic ri_reg;
   logic [7:0] rx_data_reg;
   logic [7:0] rdata_reg;
   logic ctrl_wr;
   logic data_wr;

   serial_pkg::line_state_e tx_state_reg;
   logic [3:0] tx_cnt_reg;
   logic [2:0] tx_bit_reg;
   logic [7:0] tx_shift_reg;
   logic tx_line_reg;
   logic tx_bit_end;
   logic ti_set;

   serial_pkg::line_state_e rx_state_reg;
   logic [3:0] rx_cnt_reg;
   logic [2:0] rx_bit_reg;
   logic [7:0] rx_shift_reg;
   logic rx_ninth_reg;
   logic rx_meta_reg;
   logic rx_sync_reg;
   logic rx_prev_reg;
   logic rx_sample;
   logic rx_stop_sample;
   logic rx_accept;

   stream_if #(.WIDTH(8)) txq ();

   // ************************************************
   // Register decode
   // ************************************************
   assign ctrl_wr = sfr_wr_i && (sfr_addr_i == serial_pkg::CTRL_ADDR);
   assign data_wr = sfr_wr_i && (sfr_addr_i == serial_pkg::DATA_ADDR);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         fmt_reg <= serial_pkg::CTRL_RESET[serial_pkg::FMT_BIT];
         mce_reg <= serial_pkg::CTRL_RESET[serial_pkg::MCE_BIT];
         ren_reg <= serial_pkg::CTRL_RESET[serial_pkg::REN_BIT];
         tb8_reg <= serial_pkg::CTRL_RESET[serial_pkg::TB8_BIT];
      end else if (ctrl_wr) begin
         fmt_reg <= sfr_wdata_i[serial_pkg::FMT_BIT];
         mce_reg <= sfr_wdata_i[serial_pkg::MCE_BIT];
         ren_reg <= sfr_wdata_i[serial_pkg::REN_BIT];
         tb8_reg <= sfr_wdata_i[serial_pkg::TB8_BIT];
      end
   end

   // ************************************************
   // Done flags, set wins over software write
   // ************************************************
   // transmit flag set
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ti_reg <= serial_pkg::CTRL_RESET[serial_pkg::TI_BIT];
      end else if (ti_set) begin
         ti_reg <= 1'b1;
      end else if (ctrl_wr) begin
         ti_reg <= sfr_wdata_i[serial_pkg::TI_BIT];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ri_reg <= serial_pkg::CTRL_RESET[serial_pkg::RI_BIT];
      end else if (rx_accept) begin
         ri_reg <= 1'b1;
      end else if (ctrl_wr) begin
         ri_reg <= sfr_wdata_i[serial_pkg::RI_BIT];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rb8_reg <= serial_pkg::CTRL_RESET[serial_pkg::RB8_BIT];
      end else if (rx_accept) begin
         rb8_reg <= fmt_reg ? rx_ninth_reg : rx_sync_reg;
      end else if (ctrl_wr) begin
         rb8_reg <= sfr_wdata_i[serial_pkg::RB8_BIT];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_data_reg <= 8'h00;
      end else if (rx_accept) begin
         rx_data_reg <= rx_shift_reg;
      end
   end

   // ************************************************
   // Register read
   // ************************************************
   // bit 6 reads one
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_reg <= 8'h00;
      end else if (sfr_rd_i) begin
         if (sfr_addr_i == serial_pkg::CTRL_ADDR) begin
            rdata_reg <= {fmt_reg, 1'b1, mce_reg, ren_reg,
                          tb8_reg, rb8_reg, ti_reg, ri_reg};
         end else if (sfr_addr_i == serial_pkg::DATA_ADDR) begin
            rdata_reg <= rx_data_reg;
         end else begin
            rdata_reg <= 8'h00;
         end
      end
   end

   assign sfr_rdata_o = rdata_reg;

   assign irq_o = ti_reg || ri_reg;

   // ************************************************
   // Transmit buffer
   // ************************************************
   // write queues a byte for transmission, dropped while the buffer is full
   assign txq.in_data = sfr_wdata_i;
   assign txq.in_valid = data_wr;
   assign txq.out_ready = (tx_state_reg == serial_pkg::LINE_IDLE);
   assign tx_buf_ready_o = txq.in_ready;

   stream_buffer #(
      .WIDTH(8),
      .DEPTH(serial_pkg::TX_BUF_DEPTH)
   ) tx_buffer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .s(txq)
   );

   // ************************************************
   // Transmitter
   // ************************************************
   // tick-paced bit timing
   assign tx_bit_end = baud_tick_i && (tx_cnt_reg == serial_pkg::BIT_LAST);

   assign ti_set = tx_bit_end &&
      ((tx_state_reg == serial_pkg::LINE_NINTH) ||
       (tx_state_reg == serial_pkg::LINE_DATA && !fmt_reg &&
        tx_bit_reg == serial_pkg::DATA_LAST));

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_cnt_reg <= 4'h0;
      end else if (tx_state_reg == serial_pkg::LINE_IDLE) begin
         tx_cnt_reg <= 4'h0;
      end else if (baud_tick_i) begin
         tx_cnt_reg <= tx_cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_state_reg <= serial_pkg::LINE_IDLE;
         tx_bit_reg <= 3'h0;
         tx_shift_reg <= 8'h00;
      end else begin
         unique case (tx_state_reg)
            serial_pkg::LINE_IDLE: begin
               if (txq.out_valid) begin
                  tx_shift_reg <= txq.out_data;
                  tx_bit_reg <= 3'h0;
                  tx_state_reg <= serial_pkg::LINE_START;
               end
            end
            serial_pkg::LINE_START: begin
               if (tx_bit_end) begin
                  tx_state_reg <= serial_pkg::LINE_DATA;
               end
            end
            serial_pkg::LINE_DATA: begin
               if (tx_bit_end) begin
                  tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                  tx_bit_reg <= tx_bit_reg + 3'h1;
                  if (tx_bit_reg == serial_pkg::DATA_LAST) begin
                     tx_state_reg <= fmt_reg ? serial_pkg::LINE_NINTH
                                             : serial_pkg::LINE_STOP;
                  end
               end
            end
            serial_pkg::LINE_NINTH: begin
               if (tx_bit_end) begin
                  tx_state_reg <= serial_pkg::LINE_STOP;
               end
            end
            serial_pkg::LINE_STOP: begin
               if (tx_bit_end) begin
                  tx_state_reg <= serial_pkg::LINE_IDLE;
               end
            end
            default: begin
               tx_state_reg <= serial_pkg::LINE_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_line_reg <= 1'b1;
      end else begin
         unique case (tx_state_reg)
            serial_pkg::LINE_START: tx_line_reg <= 1'b0;
            serial_pkg::LINE_DATA: tx_line_reg <= tx_shift_reg[0];
            serial_pkg::LINE_NINTH: tx_line_reg <= tb8_reg;
            default: tx_line_reg <= 1'b1;
         endcase
      end
   end

   assign tx_o = tx_line_reg;

   // ************************************************
   // Receive line synchroniser
   // ************************************************
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_meta_reg <= 1'b1;
         rx_sync_reg <= 1'b1;
         rx_prev_reg <= 1'b1;
      end else begin
         rx_meta_reg <= rx_i;
         rx_sync_reg <= rx_meta_reg;
         rx_prev_reg <= rx_sync_reg;
      end
   end

   // ************************************************
   // Receiver
   // ************************************************
   // mid-bit sample points
   assign rx_sample = baud_tick_i &&
      (rx_state_reg == serial_pkg::LINE_START ? rx_cnt_reg == serial_pkg::HALF_LAST
                                              : rx_cnt_reg == serial_pkg::BIT_LAST);
   assign rx_stop_sample = rx_sample && (rx_state_reg == serial_pkg::LINE_STOP);

   assign rx_accept = rx_stop_sample && ren_reg && !ri_reg &&
      (!mce_reg || (fmt_reg ? rx_ninth_reg : rx_sync_reg));

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_cnt_reg <= 4'h0;
      end else if (rx_state_reg == serial_pkg::LINE_IDLE || rx_sample) begin
         rx_cnt_reg <= 4'h0;
      end else if (baud_tick_i) begin
         rx_cnt_reg <= rx_cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_state_reg <= serial_pkg::LINE_IDLE;
         rx_bit_reg <= 3'h0;
         rx_shift_reg <= 8'h00;
         rx_ninth_reg <= 1'b0;
      end else if (!ren_reg) begin
         rx_state_reg <= serial_pkg::LINE_IDLE;
      end else begin
         unique case (rx_state_reg)
            serial_pkg::LINE_IDLE: begin
               if (rx_prev_reg && !rx_sync_reg) begin
                  rx_bit_reg <= 3'h0;
                  rx_state_reg <= serial_pkg::LINE_START;
               end
            end
            serial_pkg::LINE_START: begin
               if (rx_sample) begin
                  rx_state_reg <= rx_sync_reg ? serial_pkg::LINE_IDLE
                                              : serial_pkg::LINE_DATA;
               end
            end
            serial_pkg::LINE_DATA: begin
               if (rx_sample) begin
                  rx_shift_reg <= {rx_sync_reg, rx_shift_reg[7:1]};
                  rx_bit_reg <= rx_bit_reg + 3'h1;
                  if (rx_bit_reg == serial_pkg::DATA_LAST) begin
                     rx_state_reg <= fmt_reg ? serial_pkg::LINE_NINTH
                                             : serial_pkg::LINE_STOP;
                  end
               end
            end
            serial_pkg::LINE_NINTH: begin
               if (rx_sample) begin
                  rx_ninth_reg <= rx_sync_reg;
                  rx_state_reg <= serial_pkg::LINE_STOP;
               end
            end
            serial_pkg::LINE_STOP: begin
               if (rx_sample) begin
                  rx_state_reg <= serial_pkg::LINE_IDLE;
               end
            end
            default: begin
               rx_state_reg <= serial_pkg::LINE_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* logic/stream_buffer.sv */
// Small first-in first-out buffer built from flip-flops.
// Assumes DEPTH is a power of two and one clock with async reset.
`timescale 1ns/1ps
`default_nettype none
module stream_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Stream ports
   stream_if.buffer s
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [PW:0] count_reg;
   logic push;
   logic pop;

   assign s.in_ready = (count_reg != FULL_COUNT);
   assign s.out_valid = (count_reg != '0);
   assign s.out_data = mem_reg[rd_ptr_reg];
   assign push = s.in_valid && s.in_ready;
   assign pop = s.out_valid && s.out_ready;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= s.in_data;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* logic/stream_if.sv */
// Valid/ready byte stream between the register side and the buffer.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int WIDTH = 8);
   logic [WIDTH-1:0] in_data;
   logic in_valid;
   logic in_ready;
   logic [WIDTH-1:0] out_data;
   logic out_valid;
   logic out_ready;

   modport buffer (
      input in_data, in_valid, out_ready,
      output in_ready, out_data, out_valid
   );
   modport user (
      output in_data, in_valid, out_ready,
      input in_ready, out_data, out_valid
   );
endinterface
`default_nettype wire
